// >>> logic/tcp_sync2.sv
// Purpose: Two-flop synchroniser for one pin level
// Assumes: Input is asynchronous to aclk
// Notes: First stage is read only by the second
`default_nettype none
module tcp_sync2 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  // Two stages against metastability
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // tcp_sync2
`default_nettype wire

// >>> logic/tcp_unit.sv
// Purpose: 16-bit timer/counter/PWM unit with AXI4-Lite registers
// Assumes: Single clock aclk at 20 MHz, synchronous active-low reset
// Notes: Pins capture_pin and kill_pin are synchronised before use
// What this block does
// - A 16-bit counter counts up to a software-set period.
// - A capture event copies the current count into the capture register.
// - At count equal to period, counter stops or reloads, as configured.
// - Counter compared with compare register gives the PWM duty signal.
// - True and complementary outputs with programmable dead-band offset between edges.
// - Kill input forces outputs to a set state in hardware, three aclk edges after the pin (two sync flops, then the output flop).
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`default_nettype none
module tcp_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic capture_pin,
  input wire logic kill_pin,
  output logic line_out,
  output logic line_compl_out
);
  logic [3:0] ctrl_reg;
  logic [15:0] period_reg;
  logic [15:0] compare_reg;
  logic [7:0] deadband_reg;
  logic [15:0] count_reg;
  logic [15:0] capture_reg;
  logic capture_flag_reg;
  logic capture_sync;
  logic kill_sync;
  logic capture_prev_reg;
  logic pwm_reg;
  logic [7:0] dead_cnt_reg;
  logic [5:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic do_write;
  logic capture_evt;
  logic at_period;
  logic running;
  logic clr_capture_flag;
  logic aw_held_next;
  logic w_held_next;
  logic bvalid_next;
  logic rvalid_next;

  tcp_sync2 u_sync_cap (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(capture_pin),
    .q(capture_sync)
  );
  tcp_sync2 u_sync_kill (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(kill_pin),
    .q(kill_sync)
  );

  // Write side: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 6'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tcp_pkg::RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_held_next && !bvalid_next;
      s_axi_wready <= !w_held_next && !bvalid_next;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg <= tcp_pkg::OFS_DEADBAND || awaddr_reg == tcp_pkg::OFS_STATUS)
          ? tcp_pkg::RESP_OKAY : tcp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Readies are flops fed from next state, so one write is in flight
  assign aw_held_next = !do_write && (aw_held_reg || (s_axi_awvalid && s_axi_awready));
  assign w_held_next = !do_write && (w_held_reg || (s_axi_wvalid && s_axi_wready));
  assign bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);
  assign rvalid_next = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // Software-written registers; low byte lanes only matter here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= tcp_pkg::CTRL_RST;
      period_reg <= tcp_pkg::PERIOD_RST;
      compare_reg <= tcp_pkg::COMPARE_RST;
      deadband_reg <= tcp_pkg::DEADBAND_RST;
    end else if (do_write) begin
      if (awaddr_reg == tcp_pkg::OFS_CTRL && wstrb_reg[0]) begin
        ctrl_reg <= wdata_reg[3:0];
      end else if (awaddr_reg == tcp_pkg::OFS_PERIOD) begin
        if (wstrb_reg[0]) period_reg[7:0] <= wdata_reg[7:0];
        if (wstrb_reg[1]) period_reg[15:8] <= wdata_reg[15:8];
      end else if (awaddr_reg == tcp_pkg::OFS_COMPARE) begin
        if (wstrb_reg[0]) compare_reg[7:0] <= wdata_reg[7:0];
        if (wstrb_reg[1]) compare_reg[15:8] <= wdata_reg[15:8];
      end else if (awaddr_reg == tcp_pkg::OFS_DEADBAND && wstrb_reg[0]) begin
        deadband_reg <= wdata_reg[7:0];
      end
    end
  end
  assign clr_capture_flag = do_write && awaddr_reg == tcp_pkg::OFS_STATUS && wstrb_reg[0]
    && wdata_reg[0];

  // Read side, answer one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= tcp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= tcp_pkg::RESP_OKAY;
      if (s_axi_araddr == tcp_pkg::OFS_CTRL) begin
        s_axi_rdata <= {28'h0000000, ctrl_reg};
      end else if (s_axi_araddr == tcp_pkg::OFS_PERIOD) begin
        s_axi_rdata <= {16'h0000, period_reg};
      end else if (s_axi_araddr == tcp_pkg::OFS_COMPARE) begin
        s_axi_rdata <= {16'h0000, compare_reg};
      end else if (s_axi_araddr == tcp_pkg::OFS_DEADBAND) begin
        s_axi_rdata <= {24'h000000, deadband_reg};
      end else if (s_axi_araddr == tcp_pkg::OFS_COUNT) begin
        s_axi_rdata <= {16'h0000, count_reg};
      end else if (s_axi_araddr == tcp_pkg::OFS_CAPTURE) begin
        s_axi_rdata <= {16'h0000, capture_reg};
      end else if (s_axi_araddr == tcp_pkg::OFS_STATUS) begin
        s_axi_rdata <= {29'h0000000, kill_sync, running, capture_flag_reg};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= tcp_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // Read ready as a flop: low while a read answer stands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !rvalid_next;
    end
  end

  // Counter: stop or reload at period
  assign at_period = count_reg == period_reg;
  assign running = ctrl_reg[tcp_pkg::CTRL_EN_BIT] && !(at_period
    && !ctrl_reg[tcp_pkg::CTRL_RELOAD_BIT]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 16'h0000;
    end else if (!ctrl_reg[tcp_pkg::CTRL_EN_BIT]) begin
      count_reg <= 16'h0000;
    end else if (at_period) begin
      if (ctrl_reg[tcp_pkg::CTRL_RELOAD_BIT]) count_reg <= 16'h0000;
    end else begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Capture on rising edge of synchronised pin; set beats clear
  assign capture_evt = capture_sync && !capture_prev_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_prev_reg <= 1'b0;
      capture_reg <= 16'h0000;
      capture_flag_reg <= 1'b0;
    end else begin
      capture_prev_reg <= capture_sync;
      if (capture_evt) begin
        capture_reg <= count_reg;
        capture_flag_reg <= 1'b1;
      end else if (clr_capture_flag) begin
        capture_flag_reg <= 1'b0;
      end
    end
  end

  // PWM level and dead-band counter restart on every edge of it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_reg <= 1'b0;
      dead_cnt_reg <= 8'h00;
    end else begin
      pwm_reg <= ctrl_reg[tcp_pkg::CTRL_EN_BIT] && (count_reg < compare_reg);
      if ((ctrl_reg[tcp_pkg::CTRL_EN_BIT] && (count_reg < compare_reg)) != pwm_reg) begin
        dead_cnt_reg <= deadband_reg;
      end else if (dead_cnt_reg != 8'h00) begin
        dead_cnt_reg <= dead_cnt_reg - 8'h01;
      end
    end
  end

  // Outputs: both low during dead band; kill overrides everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_out <= 1'b0;
      line_compl_out <= 1'b0;
    end else if (kill_sync) begin
      line_out <= ctrl_reg[tcp_pkg::CTRL_KILL_LVL_BIT];
      line_compl_out <= ctrl_reg[tcp_pkg::CTRL_KILL_CMP_BIT];
    end else if (dead_cnt_reg != 8'h00) begin
      line_out <= 1'b0;
      line_compl_out <= 1'b0;
    end else begin
      line_out <= pwm_reg;
      line_compl_out <= !pwm_reg;
    end
  end

  AST_KILL_FORCE: assert property (@(posedge aclk) disable iff (!aresetn)
    kill_sync |=> line_out == $past(ctrl_reg[tcp_pkg::CTRL_KILL_LVL_BIT]))
    else $error("kill did not force true output");
  AST_KILL_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    kill_sync [*3] |=> line_compl_out == $past(ctrl_reg[tcp_pkg::CTRL_KILL_CMP_BIT]))
    else $error("kill did not hold complement output");
  AST_COMPL_INV: assert property (@(posedge aclk) disable iff (!aresetn)
    (!kill_sync && dead_cnt_reg == 8'h00) |=> line_compl_out == !line_out)
    else $error("complement not inverse outside dead band");
  AST_DEAD_BOTH_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    (!kill_sync && dead_cnt_reg != 8'h00) |=> !line_out && !line_compl_out)
    else $error("outputs not both low in dead band");
  AST_STOP_AT_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
    (running == 1'b0 && ctrl_reg[0] && at_period && !do_write) |=> $stable(count_reg))
    else $error("counter moved after stop at period");
  AST_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_reg[0] && ctrl_reg[1] && at_period && !do_write) |=> count_reg == 16'h0000)
    else $error("counter did not reload");
  AST_COUNT_UP: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_reg[0] && !at_period && !do_write) |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not advance");
  AST_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn)
    capture_evt |=> capture_reg == $past(count_reg) && capture_flag_reg)
    else $error("capture did not latch count");
  AST_PWM_DUTY: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_reg[0] && count_reg < compare_reg && !do_write) |=> pwm_reg)
    else $error("pwm low below compare");
endmodule // tcp_unit
`default_nettype wire

// >>> logic/tcpwm_pkg.sv
// Purpose: Constants shared by the timer/counter/PWM unit
// Assumes: 32-bit AXI4-Lite register access, 20 MHz aclk
// Notes: Offsets are byte addresses
`default_nettype none
package tcp_pkg;
  localparam int CNT_W = 16;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_PERIOD = 6'h04;
  localparam logic [5:0] OFS_COMPARE = 6'h08;
  localparam logic [5:0] OFS_DEADBAND = 6'h0C;
  localparam logic [5:0] OFS_COUNT = 6'h10;
  localparam logic [5:0] OFS_CAPTURE = 6'h14;
  localparam logic [5:0] OFS_STATUS = 6'h18;
  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RELOAD_BIT = 1;
  localparam int CTRL_KILL_LVL_BIT = 2;
  localparam int CTRL_KILL_CMP_BIT = 3;
  // Reset values, then bus response codes
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] COMPARE_RST = 16'h0000;
  localparam logic [7:0] DEADBAND_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tcp_pkg
`default_nettype wire

// >>> testbench/tcp_load_model.sv
// Purpose: Load on the true/complement pair
// Assumes: Pair drives high and low side switches
// Notes: Overcurrent trip is commanded by the bench
`default_nettype none
module tcp_load_model (
  input wire logic aclk,
  input wire logic line_out,
  input wire logic line_compl_out,
  input wire logic trip,
  output logic kill_pin,
  output logic shoot_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // Known levels before the first edge, one driver each
  logic kill_reg = 1'b0;
  logic shoot_reg = 1'b0;
  assign kill_pin = kill_reg;
  assign shoot_seen = shoot_reg;
  // Current sense trips a cycle after the bench asks
  always @(posedge aclk) begin
    kill_reg <= trip;
  end
  // Both switches on shorts the supply
  always @(posedge aclk) begin
    if (line_out && line_compl_out) begin
      shoot_reg <= 1'b1;
    end
  end
endmodule // tcp_load_model
`default_nettype wire

// >>> testbench/tcp_unit_tb_top.sv
// Purpose: Self-checking bench for the timer/PWM unit
// Assumes: AXI4-Lite master, 50 ns clock
// Notes: Register rows first, then timing cases
`default_nettype none
module tcp_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic wr; logic [5:0] a; logic [31:0] d; logic [1:0] r;} tcp_row_t;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cap, kill, trip, lo, lc, shoot;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [1:0] bresp, rresp, r;
  int bad_count, checked, hi, hc;
  tcp_row_t rows [12];
  tcp_unit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .capture_pin(cap), .kill_pin(kill),
    .line_out(lo), .line_compl_out(lc));
  tcp_load_model load (.aclk(aclk), .line_out(lo), .line_compl_out(lc),
    .trip(trip), .kill_pin(kill), .shoot_seen(shoot));
  // Free-running clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic wrap_up();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask
  // One transfer; valids drop once taken, response ends it after an idle edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    awaddr <= a; araddr <= a; wdata <= d;
    awvalid <= wr; wvalid <= wr; arvalid <= !wr; bready <= wr; rready <= !wr;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
        return;
      end
      if (rready && rvalid) begin
        r = rresp;
        q = rdata;
        rready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    chk(1, 0, "bus hang");
    wrap_up();
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // High cycles of each output over four whole periods
  task automatic meas(input logic [31:0] eh, input logic [31:0] ec);
    hi = 0;
    hc = 0;
    repeat (40) begin
      @(posedge aclk);
      hi += lo;
      hc += lc;
    end
    chk(hi, eh, "true high");
    chk(hc, ec, "compl high");
  endtask
  // Main sequence
  initial begin
    aresetn = 1'b0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; cap = 0; trip = 0; bad_count = 0; checked = 0;
    rows = '{'{0, tcp_pkg::OFS_CTRL, 0, 0}, '{0, tcp_pkg::OFS_PERIOD, 32'h0000FFFF, 0},
      '{0, tcp_pkg::OFS_COMPARE, 0, 0}, '{0, tcp_pkg::OFS_DEADBAND, 0, 0},
      '{1, tcp_pkg::OFS_PERIOD, 32'h9, 0}, '{0, tcp_pkg::OFS_PERIOD, 32'h9, 0},
      '{1, tcp_pkg::OFS_COMPARE, 32'h4, 0}, '{0, tcp_pkg::OFS_COMPARE, 32'h4, 0},
      '{1, tcp_pkg::OFS_COUNT, 32'h5, 2'h2}, '{0, tcp_pkg::OFS_COUNT, 0, 0},
      '{0, 6'h1C, 0, 2'h2}, '{1, tcp_pkg::OFS_CTRL, 32'h3, 0}};
    idle(8);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      chk(r, rows[i].r, "resp");
      if (!rows[i].wr) chk(q, rows[i].d, "read");
    end
    // Period 10, duty 4 of 10, no dead band, then dead band of 2
    idle(20);
    meas(16, 24);
    chk(hi + hc, 40, "compl inverse");
    bus(1, tcp_pkg::OFS_DEADBAND, 32'h2);
    idle(20);
    meas(8, 16);
    // Trip: true forced high, compl low
    bus(1, tcp_pkg::OFS_CTRL, 32'h7);
    trip <= 1'b1;
    idle(6);
    meas(40, 0);
    bus(0, tcp_pkg::OFS_CTRL, 0);
    meas(40, 0);
    // Opposite kill levels: true low, compl high
    bus(1, tcp_pkg::OFS_CTRL, 32'hB);
    idle(2);
    meas(0, 40);
    trip <= 1'b0;
    // Stop mode parks the count at the period
    bus(1, tcp_pkg::OFS_CTRL, 32'h1);
    idle(20);
    bus(0, tcp_pkg::OFS_COUNT, 0);
    chk(q, 32'h9, "stop count");
    cap <= 1'b1;
    idle(5);
    cap <= 1'b0;
    bus(0, tcp_pkg::OFS_CAPTURE, 0);
    chk(q, 32'h9, "capture");
    bus(0, tcp_pkg::OFS_STATUS, 0);
    chk(q, 32'h1, "status flag");
    bus(1, tcp_pkg::OFS_STATUS, 32'h1);
    bus(0, tcp_pkg::OFS_STATUS, 0);
    chk(q, 32'h0, "flag cleared");
    chk(shoot, 0, "shoot through");
    // Reset in mid-run restores defaults
    aresetn <= 1'b0;
    idle(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(lo, 0, "reset out");
    chk(lc, 0, "reset compl");
    bus(0, tcp_pkg::OFS_PERIOD, 0);
    chk(q, 32'h0000FFFF, "reset period");
    wrap_up();
  end
endmodule // tcp_unit_tb_top
`default_nettype wire
